// ==== rtl/tbsc_pkg.sv ====
// Package for the test bit stream configuration block: offsets, fields, rates
package tbsc_pkg;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 24;
  localparam logic [7:0]  ADDR_BREAK_COUNT = 8'h29;
  localparam logic [7:0]  ADDR_CONFIG      = 8'h2a;
  localparam logic [7:0]  ADDR_GAIN        = 8'h2b;
  localparam logic [23:0] RESET_VALUE      = 24'h000000;
  localparam int unsigned INTERP_MSB       = 23;
  localparam int unsigned INTERP_LSB       = 16;
  localparam int unsigned WAVE_BIT         = 15;
  localparam int unsigned RATE_MSB         = 14;
  localparam int unsigned RATE_LSB         = 12;
  localparam int unsigned SYNC_BIT         = 11;
  localparam int unsigned CLOCK_PHASE_DELAY_MSB         = 10;
  localparam int unsigned CLOCK_PHASE_DELAY_LSB         = 8;
  localparam int unsigned LOOP_BIT         = 7;
  localparam int unsigned RUN_BIT          = 6;
  localparam int unsigned DATA_BIT_DELAY_MSB         = 5;
  localparam int unsigned DATA_BIT_DELAY_LSB         = 0;
  localparam int unsigned CORE_HZ          = 40_000_000;
  localparam int unsigned BASE_HZ          = 2_048_000;
  localparam int unsigned SLOW_HZ          = 4_000;
  localparam int unsigned DELAY_DEPTH      = 64;
  localparam int unsigned PHASE_STEPS      = 8;
  // Bit period in core cycles: 2.048 MHz is not an integer divisor of 40 MHz,
  // so the rate is made by a phase accumulator in units of BASE_HZ / 2^k.
  localparam logic [31:0] ACC_STEP_BASE    = 32'(64'(BASE_HZ) * 64'h100000000 / 64'(CORE_HZ));
  localparam logic [2:0]  RATE_SLOW_CODE   = 3'h0;
  localparam int unsigned SLOW_SHIFT       = 9;
  typedef enum logic [1:0] {
    TBSC_IDLE = 2'b00,
    TBSC_WAIT = 2'b01,
    TBSC_RUN  = 2'b11
  } tbsc_state_t;
endpackage : tbsc_pkg

// ==== rtl/tbsc_delay_line.sv ====
// Bit delay line: shift register tapped at a selectable depth
`timescale 1ns/1ps
`default_nettype none
module tbsc_delay_line #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned SEL_W = 6
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_shift,
  input  wire logic             i_bit,
  input  wire logic [SEL_W-1:0] i_tap,
  output logic                  o_bit
);
  logic [DEPTH-1:0] line_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_reg <= '0;
    end else if (i_clear) begin
      // Flushed while stopped so a restart never replays an old stream
      line_reg <= '0;
    end else if (i_shift) begin
      line_reg <= {line_reg[DEPTH-2:0], i_bit};
    end
  end

  // Tap 0 is the newest bit, so the undelayed stream passes one stage only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bit <= 1'b0;
    end else begin
      o_bit <= line_reg[i_tap];
    end
  end
endmodule : tbsc_delay_line
`default_nettype wire

// ==== rtl/tbsc_top.sv ====
// Test bit stream configuration registers and stream timing
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Interpolation field bits 23:16 holds factor minus one; each value reused that often.
// R2: Bit 15 selects impulse (1) or sine (0) waveform.
// R3: Bits 14:12 select stream bit and clock rate, 4 kHz up to 2.048 MHz.
// R4: Bit 11 makes the stream start only on a sync pulse.
// R5: Bits 10:8 delay the stream clock by eighths of its period.
// R6: Bit 7 loops stream data back into the modulator data inputs.
// R7: Stream runs only while bit 6 is set.
// R8: Bits 5:0 delay stream data by 0 to 63 bit periods.
// R9: 24-bit read/write stream gain at 0x2b.
// R10: 24-bit read/write break count at 0x29.
// R11: All three registers reset to zero.
// R12: Software changes fields only with run clear, then sets run.
module tbsc_top
  import tbsc_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  input  wire logic [tbsc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [tbsc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [tbsc_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                      i_sync,
  input  wire logic                      i_pattern_bit,
  output logic                           o_sample_req,
  output logic                           o_stream_data_out,
  output logic                           o_stream_clock_out,
  input  wire logic [CHANNELS-1:0]       i_modulator_data_in,
  output logic      [CHANNELS-1:0]       o_modulator_data,
  output logic                           o_impulse_mode,
  output logic      [tbsc_pkg::DATA_W-1:0] o_stream_gain_value,
  output logic      [tbsc_pkg::DATA_W-1:0] o_break_count_value,
  output logic                           o_running
);
  import tbsc_pkg::*;

  logic [DATA_W-1:0] config_reg;
  logic [DATA_W-1:0] gain_reg;
  logic [DATA_W-1:0] break_reg;
  logic [DATA_W-1:0] rdata_next;
  tbsc_state_t       state_reg;
  tbsc_state_t       state_next;
  logic [1:0]        sync_sr_reg;
  logic              sync_prev_reg;
  logic              sync_rise;
  logic [31:0]       acc_reg;
  logic [31:0]       acc_step;
  logic [31:0]       acc_sum;
  logic              phase_wrap;
  logic [2:0]        eighth_reg;
  logic              bit_tick;
  logic [7:0]        repeat_reg;
  logic              sample_bit_reg;
  logic              delayed_bit;
  logic              run_en;
  logic [2:0]        rate_code;
  logic [2:0]        clk_delay;
  logic              stream_clear;
  logic              clock_level;
  logic [CHANNELS-1:0] mod_meta_reg;
  logic [CHANNELS-1:0] mod_sync_reg;

  assign run_en    = config_reg[RUN_BIT];
  assign rate_code = config_reg[RATE_MSB:RATE_LSB];
  assign clk_delay = config_reg[CLOCK_PHASE_DELAY_MSB:CLOCK_PHASE_DELAY_LSB];
  assign stream_clear = (state_reg != TBSC_RUN);

  // Register writes; software is expected to hold run low while retuning,
  // fields changed while running take effect at once, except the interpolation factor, which waits for its next reload
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      config_reg <= RESET_VALUE; // R11
    end else if (i_wr && (i_addr == ADDR_CONFIG)) begin
      config_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gain_reg <= RESET_VALUE; // R11
    end else if (i_wr && (i_addr == ADDR_GAIN)) begin
      gain_reg <= i_wdata; // R9
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      break_reg <= RESET_VALUE; // R11
    end else if (i_wr && (i_addr == ADDR_BREAK_COUNT)) begin
      break_reg <= i_wdata; // R10
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    case (i_addr)
      ADDR_CONFIG:      rdata_next = config_reg;
      ADDR_GAIN:        rdata_next = gain_reg; // R9
      ADDR_BREAK_COUNT: rdata_next = break_reg; // R10
      default:          rdata_next = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= '0;
    end
  end

  // Sync pin crosses into the core domain through two flops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_sr_reg <= 2'b00;
    end else begin
      sync_sr_reg <= {sync_sr_reg[0], i_sync};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= sync_sr_reg[1];
    end
  end
  assign sync_rise = sync_sr_reg[1] & ~sync_prev_reg;

  always_comb begin
    case (state_reg)
      TBSC_IDLE: begin
        if (!run_en) begin
          state_next = TBSC_IDLE;
        end else if (config_reg[SYNC_BIT]) begin // R4
          state_next = TBSC_WAIT;
        end else begin
          state_next = TBSC_RUN;
        end
      end
      // Clearing the sync bit while waiting releases the stream, so a
      // missing sync pulse cannot hold the generator forever
      TBSC_WAIT: begin
        if (!run_en) begin
          state_next = TBSC_IDLE;
        end else if (!config_reg[SYNC_BIT] || sync_rise) begin // R4
          state_next = TBSC_RUN;
        end else begin
          state_next = TBSC_WAIT;
        end
      end
      TBSC_RUN: begin
        if (run_en) begin
          state_next = TBSC_RUN;
        end else begin
          state_next = TBSC_IDLE; // R7
        end
      end
      default:   state_next = TBSC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= TBSC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Accumulator step per rate code; code 0 is the lone non-binary rate
  always_comb begin
    if (rate_code == RATE_SLOW_CODE) begin
      acc_step = ACC_STEP_BASE >> SLOW_SHIFT; // R3
    end else begin
      acc_step = ACC_STEP_BASE >> (3'h7 - rate_code); // R3
    end
  end

  // The accumulator runs at eight times the bit rate so the clock can be
  // shifted in eighths; the step is scaled up by the phase count.
  assign acc_sum    = acc_reg + (acc_step << 3);
  assign phase_wrap = (state_reg == TBSC_RUN) && (acc_sum < acc_reg);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= '0;
    end else if (stream_clear) begin
      acc_reg <= '0; // R7
    end else begin
      acc_reg <= acc_sum; // R3
    end
  end

  // Eighth of the bit period, the unit of the clock phase delay
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eighth_reg <= 3'h0;
    end else if (stream_clear) begin
      eighth_reg <= 3'h0;
    end else if (phase_wrap) begin
      eighth_reg <= eighth_reg + 3'h1;
    end
  end

  assign bit_tick = phase_wrap && (eighth_reg == 3'h7);

  // Each pattern value is held for factor bit periods before the next request
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      repeat_reg <= 8'h00;
    end else if (stream_clear) begin
      repeat_reg <= 8'h00;
    end else if (bit_tick) begin
      if (repeat_reg == 8'h00) begin
        repeat_reg <= config_reg[INTERP_MSB:INTERP_LSB]; // R1
      end else begin
        repeat_reg <= repeat_reg - 8'h01; // R1
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_bit_reg <= 1'b0;
    end else if (stream_clear) begin
      sample_bit_reg <= 1'b0;
    end else if (bit_tick) begin
      sample_bit_reg <= i_pattern_bit;
    end
  end

  // One request per reload, so a factor of N+1 bit periods per value
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_req <= 1'b0;
    end else begin
      o_sample_req <= !stream_clear && bit_tick && (repeat_reg == 8'h00); // R1
    end
  end

  tbsc_delay_line #(
    .DEPTH (DELAY_DEPTH),
    .SEL_W (DATA_BIT_DELAY_MSB - DATA_BIT_DELAY_LSB + 1)
  ) u_data_delay (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (stream_clear),
    .i_shift    (bit_tick),
    .i_bit      (sample_bit_reg),
    .i_tap      (config_reg[DATA_BIT_DELAY_MSB:DATA_BIT_DELAY_LSB]), // R8
    .o_bit      (delayed_bit)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stream_data_out <= 1'b0;
    end else if (stream_clear) begin
      o_stream_data_out <= 1'b0; // R7
    end else begin
      o_stream_data_out <= delayed_bit; // R8
    end
  end

  // High for eighths 4..7, rotated by the configured phase delay
  assign clock_level = 3'(eighth_reg - clk_delay) >= 3'(PHASE_STEPS / 2); // R5

  // The clock stands low outside a run so the converter sees no edges
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stream_clock_out <= 1'b0;
    end else if (stream_clear) begin
      o_stream_clock_out <= 1'b0; // R7
    end else begin
      o_stream_clock_out <= clock_level; // R5
    end
  end

  // Modulator pins come from another clock; two flops before any use
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mod_meta_reg <= '0;
    end else begin
      mod_meta_reg <= i_modulator_data_in;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mod_sync_reg <= '0;
    end else begin
      mod_sync_reg <= mod_meta_reg;
    end
  end

  // Loopback replaces every modulator input with the stream data
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_modulator_data <= '0;
    end else if (config_reg[LOOP_BIT]) begin
      o_modulator_data <= {CHANNELS{o_stream_data_out}}; // R6
    end else begin
      o_modulator_data <= mod_sync_reg; // R6
    end
  end

  assign o_impulse_mode      = config_reg[WAVE_BIT]; // R2
  assign o_stream_gain_value = gain_reg;
  assign o_break_count_value = break_reg;
  assign o_running           = (state_reg == TBSC_RUN);
endmodule : tbsc_top
`default_nettype wire

// ==== verification/tbsc_assertions.sv ====
// Port checks for the stream configuration block
`timescale 1ns/1ps
`default_nettype none
module tbsc_checker
  import tbsc_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic                        i_core_clk,
  input wire logic                        i_rst_n,
  input wire logic [tbsc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tbsc_pkg::DATA_W-1:0] i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [tbsc_pkg::DATA_W-1:0] o_rdata,
  input wire logic                        o_impulse_mode,
  input wire logic [tbsc_pkg::DATA_W-1:0] o_stream_gain_value,
  input wire logic [tbsc_pkg::DATA_W-1:0] o_break_count_value,
  input wire logic [CHANNELS-1:0]         i_modulator_data_in,
  input wire logic [CHANNELS-1:0]         o_modulator_data,
  input wire logic                        o_sample_req,
  input wire logic                        o_stream_data_out,
  input wire logic                        o_stream_clock_out,
  input wire logic                        o_running
);
  logic cfg_wr;
  logic loop_reg;
  logic [1:0] settle_reg;
  // Counts the cycles the modulator synchroniser needs after reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end
  assign cfg_wr = i_wr && i_addr == ADDR_CONFIG;
  // Shadow of the loop bit, since the config word has no port of its own
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loop_reg <= 1'b0;
    end else if (cfg_wr) begin
      loop_reg <= i_wdata[LOOP_BIT];
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    cfg_wr && i_wdata[RUN_BIT] && !i_wdata[SYNC_BIT] && !o_running;
  endsequence
  sequence s_stop;
    cfg_wr && !i_wdata[RUN_BIT];
  endsequence
  a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data not idle");
  a_gain_read: assert property (i_rd && i_addr == ADDR_GAIN |=> o_rdata == $past(o_stream_gain_value))
    else $error("gain read wrong");
  a_gain_write: assert property (i_wr && i_addr == ADDR_GAIN |=> o_stream_gain_value == $past(i_wdata))
    else $error("gain write lost");
  a_break_write: assert property (i_wr && i_addr == ADDR_BREAK_COUNT |=> o_break_count_value == $past(i_wdata))
    else $error("break write lost");
  a_mode_follow: assert property (cfg_wr |=> o_impulse_mode == $past(i_wdata[WAVE_BIT]))
    else $error("mode bit not followed");
  a_run_start: assert property (s_start |-> ##2 o_running)
    else $error("stream did not start");
  a_run_stop: assert property (s_stop |-> ##[1:2] !o_running)
    else $error("stream did not stop");
  a_loop_off: assert property (settle_reg == 2'h3 && !loop_reg |=> o_modulator_data == $past(i_modulator_data_in, 3))
    else $error("modulator inputs not passed");
  a_stop_quiet: assert property (!o_running |=> !o_stream_clock_out && !o_stream_data_out)
    else $error("stream active while stopped");
  a_req_idle: assert property (!o_running |=> !o_sample_req)
    else $error("sample request while stopped");
endmodule : tbsc_checker
bind tbsc_top tbsc_checker #(.CHANNELS(CHANNELS)) u_tbsc_checker (.i_core_clk, .i_rst_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_impulse_mode, .o_stream_gain_value, .o_break_count_value,
  .i_modulator_data_in, .o_modulator_data, .o_sample_req, .o_stream_data_out, .o_stream_clock_out,
  .o_running);
`default_nettype wire

// ==== verification/tbsc_conv_model.sv ====
// Test converter model: counts stream clock edges and leading zero bits
`timescale 1ns/1ps
`default_nettype none
module tbsc_conv_model (
  input  wire logic i_core_clk,
  input  wire logic i_clr,
  input  wire logic i_sclk,
  input  wire logic i_sdata,
  output var int    o_edges,
  output var int    o_lead_zeros
);
  logic sclk_reg;
  logic seen_reg;
  // Data is taken on the rising stream clock, as the converter would latch it
  always_ff @(posedge i_core_clk) begin
    sclk_reg <= i_sclk;
    if (i_clr) begin
      o_edges <= 0;
      o_lead_zeros <= 0;
      seen_reg <= 1'b0;
    end else if (i_sclk && !sclk_reg) begin
      o_edges <= o_edges + 1;
      if (i_sdata) seen_reg <= 1'b1;
      else if (!seen_reg) o_lead_zeros <= o_lead_zeros + 1;
    end
  end
endmodule : tbsc_conv_model
`default_nettype wire

// ==== verification/test_test_bit_stream_config.sv ====
// Bench for the stream configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_test_bit_stream_config;
  import tbsc_pkg::*;
  logic        clk, rst_n, wr, rd, sync, pat, clr, sreq, sdat, sclk, imp, run;
  logic [7:0]  addr;
  logic [23:0] wdata, rdata, gain, brk, v;
  logic [3:0]  mod_in, mod_out;
  int          n_fail, checked, edges, lead, n, k;
  tbsc_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_sync(sync), .i_pattern_bit(pat), .o_sample_req(sreq),
    .o_stream_data_out(sdat), .o_stream_clock_out(sclk), .i_modulator_data_in(mod_in),
    .o_modulator_data(mod_out), .o_impulse_mode(imp), .o_stream_gain_value(gain),
    .o_break_count_value(brk), .o_running(run));
  tbsc_conv_model conv (.i_core_clk(clk), .i_clr(clr), .i_sclk(sclk), .i_sdata(sdat),
    .o_edges(edges), .o_lead_zeros(lead));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [23:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd_chk
  // Clears the converter model, then counts sample requests over the span
  task automatic span(input int cyc);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    n = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1 n += int'(sreq);
    end
  endtask : span
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    {rst_n, wr, rd, sync, pat, clr, addr, wdata} = '0;
    mod_in = 4'h5;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_BREAK_COUNT, 24'h0);
    rd_chk(ADDR_CONFIG, 24'h0);
    rd_chk(ADDR_GAIN, 24'h0);
    wr_reg(ADDR_GAIN, 24'ha5c3f1);
    wr_reg(ADDR_BREAK_COUNT, 24'h5a0f3c);
    wr_reg(8'h2c, 24'hffffff);
    rd_chk(ADDR_GAIN, 24'ha5c3f1);
    rd_chk(ADDR_BREAK_COUNT, 24'h5a0f3c);
    rd_chk(8'h2c, 24'h0);
    `CHK("gain", 24'ha5c3f1, gain)
    `CHK("break", 24'h5a0f3c, brk)
    wr_reg(ADDR_CONFIG, 24'h008000);
    `CHK("impulse", 1'b1, imp)
    rd_chk(ADDR_CONFIG, 24'h008000);
    $display("registers done");
    // Every rate code, with the clock phase code riding along
    for (int c = 7; c >= 0; c--) begin
      v = 24'(c) << 12 | 24'(c) << 8;
      wr_reg(ADDR_CONFIG, v);
      `CHK("impulse", 1'b0, imp)
      wr_reg(ADDR_CONFIG, v | 24'h40);
      k = (c > 0) ? 8 : 2;
      span(k * 40_000_000 / ((c > 0) ? (2_048_000 >> (7 - c)) : 4_000));
      `CHK("edges", 1'b1, edges >= k - 1 && edges <= k + 1)
    end
    wr_reg(ADDR_CONFIG, 24'h7000);
    repeat (2) @(posedge clk);
    #1 `CHK("running", 1'b0, run)
    for (int f = 0; f < 4; f += 3) begin
      wr_reg(ADDR_CONFIG, 24'(f) << 16 | 24'h7000);
      wr_reg(ADDR_CONFIG, 24'(f) << 16 | 24'h7040);
      span(1250);
      `CHK("requests", 1'b1, n >= 64 / (f + 1) - 2 && n <= 64 / (f + 1) + 2)
    end
    $display("rates done");
    for (int d = 63; d >= 0; d -= 63) begin
      wr_reg(ADDR_CONFIG, 24'h7000 | 24'(d));
      pat <= 1'b1;
      wr_reg(ADDR_CONFIG, 24'h7040 | 24'(d));
      span((d + 8) * 20);
      `CHK("lead", 1'b1, lead >= d && lead <= d + 3)
    end
    `CHK("no loop", 4'h5, mod_out)
    wr_reg(ADDR_CONFIG, 24'h7080);
    wr_reg(ADDR_CONFIG, 24'h70c0);
    span(200);
    `CHK("loop", 4'hf, mod_out)
    wr_reg(ADDR_CONFIG, 24'h7800);
    wr_reg(ADDR_CONFIG, 24'h7840);
    repeat (10) @(posedge clk);
    #1 `CHK("held", 1'b0, run)
    @(posedge clk);
    sync <= 1'b1;
    k = 0;
    while (run !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK("synced", 1'b1, run)
    $display("stream done");
    close_out();
  end
endmodule : test_test_bit_stream_config
`default_nettype wire
